//--- rtl/sfd_switch_diag.sv
// What this block does
// - Retry armed per output when its overcurrent, overtemp or shared undervoltage is set
// - Each retry re-enables output after one retry period; at most 16 retries
// - Retry counters clear on any fail-safe to normal change either way
// - Each retry restores default overcurrent settings for lamp inrush
// - Short-to-supply checked when off, latched after gate low, sets two flags
// - Latched short-to-supply flag clears on status read once the short is gone
// - Per-output disable bit suppresses short-to-supply detection
// - Off openload latched when output off and above threshold; read clears when gone
// - Per-output disable bit suppresses off-state openload detection
// - On openload flag set below bulb or LED threshold; output and fault pin unaffected
// - LED mode checks once per LED openload period at full duty, PWM enabled
// - On openload flag stays until condition gone and a read occurs
// - Per-output disable bit suppresses on-state openload detection
// - Sense output routed by temp enable, sense enable, select and ratio settings
// - Current recopy only while selected switch on, never in fail-safe
// - In normal mode temp prewarning latched; cleared only by a read
// - Supply above clamp level cancels turn-off and switches all outputs on unless ground is lost
// - Ground loss turns every output off whatever its command
// - Logic supply fail with enable bit set resets all configuration registers; latched status flags are kept
// - Without logic supply outputs follow direct inputs, protections use zero config
// - Power supply loss keeps configuration and access, reports undervoltage
// - Both supplies below reset level clear registers and latched faults
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module sfd_switch_diag #(
   parameter int RETRY_CYCLES  = sfd_pkg::RETRY_CYCLES,
   parameter int LED_OL_CYCLES = sfd_pkg::LED_OL_CYCLES
) (
   // Clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_nrst,
   // APB slave
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [7:0]          i_paddr,
   input  wire logic [31:0]         i_pwdata,
   output logic      [31:0]         o_prdata,
   output logic                     o_pready,
   output logic                     o_pslverr,
   // Comparator and supply monitors
   input  wire sfd_pkg::sfd_analog_t i_analog,
   input  wire logic [3:0]          i_direct_in,
   input  wire logic                i_failsafe,
   // Outputs
   output logic [3:0]               o_high_side_output,
   output logic [3:0]               o_oc_default,
   output logic                     o_fault_status_pin_n,
   output logic                     o_sense_current_en,
   output logic                     o_sense_temp_en,
   output logic [1:0]               o_sense_routing_select,
   output logic                     o_sense_ratio_select
);
   localparam int CW = 32;

   sfd_pkg::sfd_analog_t a_meta_ff;
   sfd_pkg::sfd_analog_t a_ff;
   logic [3:0]           din_meta_ff;
   logic [3:0]           din_ff;
   logic                 fs_meta_ff;
   logic                 fs_ff;
   logic                 fs_prev_ff;

   logic [3:0]  cmd_on_ff;
   logic [15:0] conf_ff;
   logic [6:0]  gcfg_ff;
   logic [31:0] duty_ff;
   logic [3:0]  oc_flag_ff;
   logic [3:0]  ot_flag_ff;
   logic        uv_flag_ff;
   logic [3:0]  short_to_supply_flag_ff;
   logic [3:0]  off_openload_flag_ff;
   logic [3:0]  on_openload_flag_ff;
   logic        temp_prewarning_flag_ff;
   logic [3:0]  latched_off_ff;
   logic [3:0]  cmd_prev_ff;
   logic [CW-1:0] led_cnt_ff;
   logic        led_tick;

   sfd_pkg::sfd_rt_state_t rt_st_ff [4];
   logic [CW-1:0]          rt_cnt_ff [4];
   logic [4:0]             rt_num_ff [4];

   logic        wr_en;
   logic        rd_en;
   logic        st_rd;
   logic        dg_rd;
   logic        cfg_rst;
   logic        por;
   logic        no_lsup;
   logic [15:0] eff_conf;
   logic [3:0]  retry_pulse;
   logic [3:0]  nxt_hs;
   logic [3:0]  os_set;
   logic [3:0]  ol_set;
   logic [3:0]  on_set;
   logic [3:0]  led_ok;
   logic [3:0]  trig;
   logic        mode_chg;

   function automatic logic [3:0] clr_flag(input logic [3:0] flag, input logic [3:0] set_v,
                                           input logic [3:0] cond, input logic rd);
      clr_flag = set_v | (flag & ~(rd ? ~cond : 4'h0));
   endfunction

   // Two-stage synchronisers for pin-level inputs
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         a_meta_ff   <= '0;
         a_ff        <= '0;
         din_meta_ff <= 4'h0;
         din_ff      <= 4'h0;
         fs_meta_ff  <= 1'b0;
         fs_ff       <= 1'b0;
         fs_prev_ff  <= 1'b0;
      end else begin
         a_meta_ff   <= i_analog;
         a_ff        <= a_meta_ff;
         din_meta_ff <= i_direct_in;
         din_ff      <= din_meta_ff;
         fs_meta_ff  <= i_failsafe;
         fs_ff       <= fs_meta_ff;
         fs_prev_ff  <= fs_ff;
      end
   end

   assign wr_en   = i_psel && i_penable && i_pwrite;
   assign rd_en   = i_psel && i_penable && !i_pwrite;
   assign st_rd   = rd_en && (i_paddr == sfd_pkg::ADDR_STATUS);
   assign dg_rd   = rd_en && (i_paddr == sfd_pkg::ADDR_DIAG);
   assign por     = a_ff.lsup_fail && a_ff.psup_fail;
   assign no_lsup = a_ff.lsup_fail;
   assign cfg_rst = por || (no_lsup && gcfg_ff[sfd_pkg::G_LSUP_FAIL_EN]);
   // Without logic supply every per-output configuration bit acts as zero
   assign eff_conf = no_lsup ? 16'h0000 : conf_ff;

   // Configuration registers; kept on power supply loss alone
   always_ff @(posedge i_clk) begin
      if (!i_nrst || cfg_rst) begin
         cmd_on_ff <= 4'h0;
         conf_ff   <= 16'h0000;
         gcfg_ff   <= 7'h00;
         duty_ff   <= 32'h0000_0000;
      end else if (wr_en) begin
         case (i_paddr)
            sfd_pkg::ADDR_CTRL: cmd_on_ff <= i_pwdata[3:0];
            sfd_pkg::ADDR_CONF: conf_ff   <= i_pwdata[15:0];
            sfd_pkg::ADDR_GCFG: gcfg_ff   <= i_pwdata[6:0];
            sfd_pkg::ADDR_DUTY: duty_ff   <= i_pwdata;
            default: ;
         endcase
      end
   end

   // LED openload check tick
   always_ff @(posedge i_clk) begin
      if (!i_nrst || led_cnt_ff == CW'(LED_OL_CYCLES - 1)) begin
         led_cnt_ff <= '0;
      end else begin
         led_cnt_ff <= led_cnt_ff + 1'b1;
      end
   end
   assign led_tick = (led_cnt_ff == CW'(LED_OL_CYCLES - 1));

   // Per-output set conditions of the latched diagnostics
   always_comb begin
      os_set = 4'h0;
      ol_set = 4'h0;
      on_set = 4'h0;
      led_ok = 4'h0;
      for (int i = 0; i < 4; i++) begin
         os_set[i] = !o_high_side_output[i] && a_ff.off_short[i] && a_ff.gate_low[i]
                     && !eff_conf[sfd_pkg::C_SHORT_TO_SUPPLY_DETECT_DISABLE + i];
         ol_set[i] = !o_high_side_output[i] && a_ff.off_open[i] && a_ff.gate_low[i]
                     && !eff_conf[sfd_pkg::C_OFF_OPENLOAD_DETECT_DISABLE + i];
         led_ok[i] = led_tick && gcfg_ff[sfd_pkg::G_PWM_EN]
                     && duty_ff[8*i +: 8] == sfd_pkg::FULL_DUTY;
         on_set[i] = o_high_side_output[i] && !eff_conf[sfd_pkg::C_ON_OPENLOAD_DETECT_DISABLE + i]
                     && (eff_conf[sfd_pkg::C_LED_SEL + i] ? (a_ff.on_low_led[i] && led_ok[i])
                                                         : a_ff.on_low_bulb[i]);
      end
   end

   // Protection and diagnostic flags; a new event wins over a read clear
   always_ff @(posedge i_clk) begin
      if (!i_nrst || por) begin
         oc_flag_ff              <= 4'h0;
         ot_flag_ff              <= 4'h0;
         uv_flag_ff              <= 1'b0;
         short_to_supply_flag_ff <= 4'h0;
         off_openload_flag_ff    <= 4'h0;
         on_openload_flag_ff     <= 4'h0;
         temp_prewarning_flag_ff <= 1'b0;
      end else begin
         oc_flag_ff <= clr_flag(oc_flag_ff, a_ff.overcurrent, 4'h0, st_rd);
         ot_flag_ff <= clr_flag(ot_flag_ff, a_ff.overtemp, 4'h0, st_rd);
         uv_flag_ff <= a_ff.undervoltage || a_ff.psup_fail || (uv_flag_ff && !st_rd);
         short_to_supply_flag_ff <= clr_flag(short_to_supply_flag_ff, os_set,
                                             a_ff.off_short, st_rd);
         off_openload_flag_ff <= clr_flag(off_openload_flag_ff, os_set | ol_set,
                                          a_ff.off_open | a_ff.off_short, st_rd);
         on_openload_flag_ff <= clr_flag(on_openload_flag_ff, on_set,
                                         a_ff.on_low_bulb | a_ff.on_low_led, st_rd);
         temp_prewarning_flag_ff <= (!fs_ff && a_ff.gnd_hot)
                                    || (temp_prewarning_flag_ff && !dg_rd);
      end
   end

   // Per-output autoretry sequencers
   assign mode_chg = fs_ff != fs_prev_ff;
   assign trig     = oc_flag_ff | ot_flag_ff | {4{uv_flag_ff}};

   always_ff @(posedge i_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (!i_nrst || por) begin
            rt_st_ff[i]  <= sfd_pkg::RT_IDLE;
            rt_cnt_ff[i] <= '0;
            rt_num_ff[i] <= 5'h00;
         end else begin
            // Count survives a command toggle; only a mode change restarts it
            if (mode_chg) begin
               rt_num_ff[i] <= 5'h00;
            end
            case (rt_st_ff[i])
               sfd_pkg::RT_IDLE: begin
                  rt_cnt_ff[i] <= '0;
                  if (trig[i] && cmd_prev_ff[i]) begin
                     rt_st_ff[i] <= (rt_num_ff[i] == 5'(sfd_pkg::RETRY_LIMIT))
                                    ? sfd_pkg::RT_LATCH : sfd_pkg::RT_WAIT;
                  end
               end
               sfd_pkg::RT_WAIT: begin
                  if (rt_cnt_ff[i] == CW'(RETRY_CYCLES - 1)) begin
                     rt_st_ff[i] <= sfd_pkg::RT_RETRY;
                  end else begin
                     rt_cnt_ff[i] <= rt_cnt_ff[i] + 1'b1;
                  end
               end
               sfd_pkg::RT_RETRY: begin
                  if (!mode_chg) begin
                     rt_num_ff[i] <= rt_num_ff[i] + 5'h01;
                  end
                  rt_st_ff[i] <= sfd_pkg::RT_IDLE;
               end
               sfd_pkg::RT_LATCH: begin
                  if (!cmd_on_ff[i] || mode_chg) begin
                     rt_st_ff[i] <= sfd_pkg::RT_IDLE;
                  end
               end
               default: rt_st_ff[i] <= sfd_pkg::RT_IDLE;
            endcase
         end
      end
   end

   // One-cycle retry strobe, also the overcurrent default restore
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         retry_pulse[i] = rt_st_ff[i] == sfd_pkg::RT_RETRY;
      end
   end

   // Output latch-off and gating
   always_ff @(posedge i_clk) begin
      if (!i_nrst || por) begin
         latched_off_ff <= 4'h0;
         cmd_prev_ff    <= 4'h0;
      end else begin
         cmd_prev_ff <= nxt_hs & ~latched_off_ff;
         for (int i = 0; i < 4; i++) begin
            // Retry or full command release wins, so each retry re-enables once
            if ((!cmd_on_ff[i] && !din_ff[i]) || retry_pulse[i]) begin
               latched_off_ff[i] <= 1'b0;
            end else if (a_ff.overcurrent[i] || a_ff.overtemp[i] || a_ff.undervoltage) begin
               latched_off_ff[i] <= 1'b1;
            end
         end
      end
   end

   // Ground loss overrides clamp, clamp overrides latch-off
   always_comb begin
      // No logic supply: direct inputs alone drive the outputs
      nxt_hs = no_lsup ? din_ff : (cmd_on_ff | din_ff);
      nxt_hs = nxt_hs & ~latched_off_ff;
      if (a_ff.clamp) begin
         nxt_hs = 4'hf;
      end
      if (a_ff.gnd_loss) begin
         nxt_hs = 4'h0;
      end
   end

   // Registered pins
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_high_side_output     <= 4'h0;
         o_oc_default           <= 4'h0;
         o_fault_status_pin_n   <= 1'b1;
         o_sense_current_en     <= 1'b0;
         o_sense_temp_en        <= 1'b0;
         o_sense_routing_select <= 2'b00;
         o_sense_ratio_select   <= 1'b0;
      end else begin
         o_high_side_output <= nxt_hs;
         o_oc_default       <= retry_pulse;
         o_fault_status_pin_n <= !(|(a_ff.off_short & ~o_high_side_output
                                     & ~eff_conf[sfd_pkg::C_SHORT_TO_SUPPLY_DETECT_DISABLE +: 4])
                                   || |latched_off_ff);
         o_sense_temp_en <= !no_lsup && gcfg_ff[sfd_pkg::G_TEMP_EN];
         o_sense_current_en <= !no_lsup && !fs_ff && !gcfg_ff[sfd_pkg::G_TEMP_EN]
                               && gcfg_ff[sfd_pkg::G_SENSE_EN]
                               && nxt_hs[gcfg_ff[sfd_pkg::G_SEL_LO +: 2]];
         o_sense_routing_select <= gcfg_ff[sfd_pkg::G_SEL_LO +: 2];
         o_sense_ratio_select   <= gcfg_ff[sfd_pkg::G_RATIO];
      end
   end

   // APB read data, zero wait states
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && (i_paddr > sfd_pkg::ADDR_DUTY
                                               || i_paddr[1:0] != 2'b00);
         case (i_paddr)
            sfd_pkg::ADDR_CTRL:   o_prdata <= {28'h0, cmd_on_ff};
            sfd_pkg::ADDR_CONF:   o_prdata <= {16'h0, conf_ff};
            sfd_pkg::ADDR_GCFG:   o_prdata <= {25'h0, gcfg_ff};
            sfd_pkg::ADDR_STATUS: o_prdata <= {11'h0, uv_flag_ff, on_openload_flag_ff,
                                               off_openload_flag_ff, short_to_supply_flag_ff,
                                               ot_flag_ff, oc_flag_ff};
            sfd_pkg::ADDR_DIAG:   o_prdata <= {27'h0, temp_prewarning_flag_ff, o_oc_default};
            sfd_pkg::ADDR_DUTY:   o_prdata <= duty_ff;
            default:              o_prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

//--- rtl/sfd_pkg.sv
package sfd_pkg;
   localparam int NCH            = 4;
   localparam int RETRY_LIMIT    = 16;
   localparam int CLK_MHZ        = 100;
   // Retry period and LED openload period in microseconds (plain defaults)
   localparam int RETRY_PERIOD_US  = 150;
   localparam int LED_OL_PERIOD_US = 100;
   localparam int RETRY_CYCLES   = RETRY_PERIOD_US * CLK_MHZ;
   localparam int LED_OL_CYCLES  = LED_OL_PERIOD_US * CLK_MHZ;
   localparam logic [7:0] FULL_DUTY = 8'hff;

   // APB register byte offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CONF   = 8'h04;
   localparam logic [7:0] ADDR_GCFG   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_DIAG   = 8'h10;
   localparam logic [7:0] ADDR_DUTY   = 8'h14;

   // Global configuration field positions
   localparam int G_TEMP_EN     = 0;
   localparam int G_SENSE_EN    = 1;
   localparam int G_SEL_LO      = 2;
   localparam int G_RATIO       = 4;
   localparam int G_PWM_EN      = 5;
   localparam int G_LSUP_FAIL_EN = 6;

   // Per-channel configuration, 4 bits apart per field group
   localparam int C_SHORT_TO_SUPPLY_DETECT_DISABLE    = 0;
   localparam int C_OFF_OPENLOAD_DETECT_DISABLE = 4;
   localparam int C_ON_OPENLOAD_DETECT_DISABLE  = 8;
   localparam int C_LED_SEL   = 12;

   typedef struct packed {
      logic [3:0] overcurrent;
      logic [3:0] overtemp;
      logic       undervoltage;
      logic [3:0] off_short;
      logic [3:0] off_open;
      logic [3:0] on_low_bulb;
      logic [3:0] on_low_led;
      logic       gnd_hot;
      logic       clamp;
      logic       gnd_loss;
      logic       lsup_fail;
      logic       psup_fail;
      logic [3:0] gate_low;
   } sfd_analog_t;

   typedef enum logic [1:0] {
      RT_IDLE  = 2'b00,
      RT_WAIT  = 2'b01,
      RT_RETRY = 2'b10,
      RT_LATCH = 2'b11
   } sfd_rt_state_t;
endpackage

//--- verification/sfd_switch_diag_assertions.sv
`timescale 1ns/1ns
module sfd_switch_diag_assertions (
   // Clock and reset
   input wire logic                 i_clk,
   input wire logic                 i_nrst,
   // Bus
   input wire logic                 i_psel,
   input wire logic                 i_penable,
   input wire logic [7:0]           i_paddr,
   input wire logic [31:0]          o_prdata,
   input wire logic                 o_pready,
   input wire logic                 o_pslverr,
   // Monitors and outputs
   input wire sfd_pkg::sfd_analog_t i_analog,
   input wire logic                 i_failsafe,
   input wire logic [3:0]           o_high_side_output,
   input wire logic [3:0]           o_oc_default,
   input wire logic                 o_sense_current_en,
   input wire logic                 o_sense_temp_en,
   input wire logic [1:0]           o_sense_routing_select
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_ready_one;
      o_pready |=> !o_pready;
   endproperty
   property p_ready_access;
      o_pready |-> i_psel && i_penable;
   endproperty
   property p_unmapped;
      (i_psel && !i_penable && i_paddr > 8'h14) |=> o_pready && o_pslverr && o_prdata == 32'h0;
   endproperty
   property p_gnd_off;
      (i_analog.gnd_loss && !i_analog.clamp) [*5] |-> o_high_side_output == 4'h0;
   endproperty
   property p_clamp_on;
      (i_analog.clamp && !i_analog.gnd_loss) [*5] |-> o_high_side_output == 4'hf;
   endproperty
   property p_oc_pulse;
      |o_oc_default |=> o_oc_default == 4'h0;
   endproperty
   property p_failsafe_sense;
      i_failsafe [*5] |-> !o_sense_current_en;
   endproperty
   property p_sense_on;
      o_sense_current_en |-> o_high_side_output[o_sense_routing_select]
         || $past(o_high_side_output[o_sense_routing_select]);
   endproperty
   property p_temp_first;
      o_sense_temp_en |-> !o_sense_current_en;
   endproperty

   a_ready_one:      assert property (p_ready_one) else $error("pready longer than one cycle");
   a_ready_access:   assert property (p_ready_access) else $error("pready outside access");
   a_unmapped:       assert property (p_unmapped) else $error("unmapped access not refused");
   a_gnd_off:        assert property (p_gnd_off) else $error("output on after ground loss");
   a_clamp_on:       assert property (p_clamp_on) else $error("clamp left output off");
   a_oc_pulse:       assert property (p_oc_pulse) else $error("default restore not a pulse");
   a_failsafe_sense: assert property (p_failsafe_sense) else $error("recopy in fail-safe");
   a_sense_on:       assert property (p_sense_on) else $error("recopy with switch off");
   a_temp_first:     assert property (p_temp_first) else $error("temp and current both routed");

   c_retry:  cover property (|o_oc_default);
   c_refuse: cover property (o_pready && o_pslverr);
   c_temp:   cover property (o_sense_temp_en);
endmodule

bind sfd_switch_diag sfd_switch_diag_assertions u_sfd_switch_diag_assertions (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
   .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_analog(i_analog), .i_failsafe(i_failsafe), .o_high_side_output(o_high_side_output),
   .o_oc_default(o_oc_default), .o_sense_current_en(o_sense_current_en),
   .o_sense_temp_en(o_sense_temp_en), .o_sense_routing_select(o_sense_routing_select));

//--- verification/sfd_host.sv
`timescale 1ns/1ns
module sfd_host (
   // Clock
   input  wire logic        i_clk,
   // Bus master side
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [7:0]       o_paddr,
   output logic [31:0]      o_pwdata,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0;
   end

   // Setup, then access held until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] d, output logic e);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= v;
      @(posedge i_clk);
      o_penable <= 1'b1;
      @(posedge i_clk);
      while (i_pready !== 1'b1) @(posedge i_clk);
      d = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_pwdata <= ~v;
   endtask
endmodule

//--- verification/tb_sfd_switch_diag.sv
`timescale 1ns/1ns
module tb_sfd_switch_diag;
   logic                 i_clk, i_nrst, psel, pen, pwr, rdy, err, fs_n, cen, ten, rat, fsafe, lerr;
   logic [7:0]           pad;
   logic [31:0]          pwd, prd, d;
   logic [3:0]           hs, ocd, din;
   logic [1:0]           sel;
   sfd_pkg::sfd_analog_t an;
   int                   fails, comparisons, pulses;

   sfd_switch_diag #(.RETRY_CYCLES(20), .LED_OL_CYCLES(10)) u_sfd_switch_diag (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(pad), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
      .i_analog(an), .i_direct_in(din), .i_failsafe(fsafe), .o_high_side_output(hs),
      .o_oc_default(ocd), .o_fault_status_pin_n(fs_n), .o_sense_current_en(cen),
      .o_sense_temp_en(ten), .o_sense_routing_select(sel), .o_sense_ratio_select(rat));
   sfd_host u_sfd_host (.i_clk(i_clk), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
      .o_paddr(pad), .o_pwdata(pwd), .i_prdata(prd), .i_pready(rdy), .i_pslverr(err));

   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) if (ocd[0] === 1'b1) pulses <= pulses + 1;

   task automatic wt(input int n); repeat (n) @(posedge i_clk); endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      logic y;
      u_sfd_host.xfer(1'b1, a, v, x, y);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      u_sfd_host.xfer(1'b0, a, 32'h0, v, lerr);
   endtask
   task automatic t_regs;
      rd(sfd_pkg::ADDR_CONF, d); chk("conf reset", d, 32'h0);
      wr(sfd_pkg::ADDR_DUTY, 32'hff00ff00); rd(sfd_pkg::ADDR_DUTY, d); chk("duty", d, 32'hff00ff00);
      wr(sfd_pkg::ADDR_STATUS, 32'hffffffff); rd(sfd_pkg::ADDR_STATUS, d); chk("status ro", d, 32'h0);
      rd(8'h18, d); chk("unmapped data", d, 32'h0);
      chk("unmapped err", {31'h0, lerr}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_short;
      an.off_short[1] <= 1'b1; an.gate_low[1] <= 1'b1; wt(6);
      chk("fault pin", {31'h0, fs_n}, 32'h0);
      rd(sfd_pkg::ADDR_STATUS, d); chk("short flags", d & 32'h2200, 32'h2200);
      an.off_short[1] <= 1'b0; wt(6);
      chk("fault pin free", {31'h0, fs_n}, 32'h1);
      rd(sfd_pkg::ADDR_STATUS, d); chk("short held", d & 32'h2200, 32'h2200);
      rd(sfd_pkg::ADDR_STATUS, d); chk("short cleared", d & 32'h2200, 32'h0);
      wr(sfd_pkg::ADDR_CONF, 32'h22); an.off_short[1] <= 1'b1; an.off_open[1] <= 1'b1; wt(6);
      rd(sfd_pkg::ADDR_STATUS, d); chk("disabled", d & 32'h2200, 32'h0);
      an.off_short[1] <= 1'b0; an.off_open[1] <= 1'b0; wr(sfd_pkg::ADDR_CONF, 32'h0);
      $display("t_short done");
   endtask
   task automatic t_onopen;
      wr(sfd_pkg::ADDR_CTRL, 32'h4); an.on_low_bulb[2] <= 1'b1; wt(6);
      chk("still on", {28'h0, hs}, 32'h4);
      chk("pin calm", {31'h0, fs_n}, 32'h1);
      an.on_low_bulb[2] <= 1'b0; wt(6);
      rd(sfd_pkg::ADDR_STATUS, d); chk("onopen held", d & 32'h40000, 32'h40000);
      rd(sfd_pkg::ADDR_STATUS, d); chk("onopen clr", d & 32'h40000, 32'h0);
      wr(sfd_pkg::ADDR_CONF, 32'h400); an.on_low_bulb[2] <= 1'b1; wt(6);
      rd(sfd_pkg::ADDR_STATUS, d); chk("onopen off", d & 32'h40000, 32'h0);
      an.on_low_bulb[2] <= 1'b0; wr(sfd_pkg::ADDR_CONF, 32'h0); wr(sfd_pkg::ADDR_CTRL, 32'h0);
      // LED mode on outputs 0 and 1; of these only output 1 runs at full duty
      wr(sfd_pkg::ADDR_CONF, 32'h3000); wr(sfd_pkg::ADDR_GCFG, 32'h20); wr(sfd_pkg::ADDR_CTRL, 32'h3);
      an.on_low_led[1:0] <= 2'b11; wt(25); an.on_low_led[1:0] <= 2'b00; wt(6);
      rd(sfd_pkg::ADDR_STATUS, d); chk("led openload", d & 32'h30000, 32'h20000);
      wr(sfd_pkg::ADDR_GCFG, 32'h0); an.on_low_led[1] <= 1'b1; wt(25);
      an.on_low_led[1] <= 1'b0; wt(6);
      rd(sfd_pkg::ADDR_STATUS, d); chk("led no pwm", d & 32'h20000, 32'h0);
      wr(sfd_pkg::ADDR_CONF, 32'h0); wr(sfd_pkg::ADDR_CTRL, 32'h0);
      $display("t_onopen done");
   endtask
   task automatic t_retry;
      wr(sfd_pkg::ADDR_CTRL, 32'h1); wt(6);
      // Second round only retries if the mode change restarted the count
      for (int k = 0; k < 2; k++) begin
         pulses <= 0; an.overcurrent[0] <= 1'b1;
         wt(1500);
         chk("retries", pulses, sfd_pkg::RETRY_LIMIT);
         chk("latched off", {31'h0, hs[0]}, 32'h0);
         an.overcurrent[0] <= 1'b0; wt(6); rd(sfd_pkg::ADDR_STATUS, d);
         wr(sfd_pkg::ADDR_CTRL, 32'h0); wr(sfd_pkg::ADDR_CTRL, 32'h1); wt(6);
         chk("delatched", {31'h0, hs[0]}, 32'h1);
         fsafe <= 1'b1; wt(6); fsafe <= 1'b0; wt(6);
      end
      wr(sfd_pkg::ADDR_CTRL, 32'h0);
      $display("t_retry done");
   endtask
   task automatic t_misc;
      an.gnd_hot <= 1'b1; wt(6); an.gnd_hot <= 1'b0; wt(6);
      rd(sfd_pkg::ADDR_DIAG, d); chk("prewarn", d & 32'h10, 32'h10);
      rd(sfd_pkg::ADDR_DIAG, d); chk("prewarn clr", d & 32'h10, 32'h0);
      wr(sfd_pkg::ADDR_CTRL, 32'h4); wr(sfd_pkg::ADDR_GCFG, 32'h1a); wt(6);
      chk("route", {cen, ten, sel, rat}, 5'b10101);
      fsafe <= 1'b1; wt(6); chk("fs recopy", {31'h0, cen}, 32'h0);
      fsafe <= 1'b0; wr(sfd_pkg::ADDR_GCFG, 32'h1b); wt(6);
      chk("temp route", {cen, ten}, 2'b01);
      an.gnd_loss <= 1'b1; wt(6); chk("gnd off", {28'h0, hs}, 32'h0);
      an.gnd_loss <= 1'b0; wr(sfd_pkg::ADDR_CTRL, 32'h0); an.clamp <= 1'b1; wt(6);
      chk("clamp on", {28'h0, hs}, 32'hf);
      an.clamp <= 1'b0; wr(sfd_pkg::ADDR_CONF, 32'h5); an.psup_fail <= 1'b1; wt(6);
      rd(sfd_pkg::ADDR_CONF, d); chk("keep conf", d, 32'h5);
      rd(sfd_pkg::ADDR_STATUS, d); chk("uv", d & 32'h100000, 32'h100000);
      an.psup_fail <= 1'b0; an.lsup_fail <= 1'b1; din <= 4'h8; wt(6);
      chk("direct", {28'h0, hs}, 32'h8);
      an.psup_fail <= 1'b1; wt(6); an.psup_fail <= 1'b0; an.lsup_fail <= 1'b0; din <= 4'h0;
      wt(6); rd(sfd_pkg::ADDR_CONF, d); chk("por conf", d, 32'h0);
      wr(sfd_pkg::ADDR_GCFG, 32'h40); wr(sfd_pkg::ADDR_CONF, 32'h5);
      an.lsup_fail <= 1'b1; wt(6); an.lsup_fail <= 1'b0; wt(6);
      rd(sfd_pkg::ADDR_CONF, d); chk("lsup conf", d, 32'h0);
      $display("t_misc done");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #300000;
      fails++;
      print_verdict;
   end
   initial begin
      i_clk = 1'b0; i_nrst = 1'b0; an = '0; din = 4'h0; fsafe = 1'b0; pulses = 0;
      wt(6); i_nrst <= 1'b1; wt(1);
      t_regs; t_short; t_onopen; t_retry; t_misc;
      print_verdict;
   end
endmodule
